// ### rtl/rail_seq_defs.vh
// constants for the rail turn-off, restart and retry sequencer
`ifndef RAIL_SEQ_DEFS_VH
`define RAIL_SEQ_DEFS_VH
// command codes
`define CMD_CLEAR_FAULTS  8'h03
`define CMD_OUT_OV_RESP   8'h41
`define CMD_OUT_UV_RESP   8'h45
`define CMD_IN_OV_RESP    8'h56
`define CMD_START_RESP    8'h63
`define CMD_TOFF_DELAY    8'h64
`define CMD_FALL_TIME     8'h65
`define CMD_WARN_LIMIT    8'h66
`define CMD_STATUS_BYTE   8'h78
`define CMD_STATUS_WORD   8'h79
`define CMD_STATUS_INPUT  8'h7c
`define CMD_CHAN_CONFIG   8'hd0
`define CMD_RETRY_IVL     8'hdb
`define CMD_RESTART_HOLD  8'hdc
// reset values
`define RST_OUT_OV_RESP   8'hb8
`define RST_OUT_UV_RESP   8'hb8
`define RST_IN_OV_RESP    8'h80
`define RST_START_RESP    8'hb8
`define RST_TOFF_DELAY    16'h8000
`define RST_FALL_TIME     16'hd200
`define RST_WARN_LIMIT    16'hf258
`define RST_RETRY_IVL     16'hfabc
`define RST_RESTART_HOLD  16'hfbe8
`define RST_CHAN_CONFIG   8'h00
// field positions and codes
`define CFG_NO_RETRY_DECAY 0
`define CFG_DECAY_CHECK    1
`define SB_NONE_ABOVE      0
`define SWH_INPUT          5
`define SIN_IN_OV          7
`define RESP_SHUT          2'b10
`define RESP_DELAYED       2'b01
`define RETRY_FOREVER      3'b111
// timing: time base is one subtick of 1/16 ms
`define CLK_NS            20
`define SUBTICK_NS        62500
`define SUBTICK_CYC       (`SUBTICK_NS / `CLK_NS)
`define UNIT_SHIFT        4
`define FALL_MIN          32'd4
`define FALL_MAX          32'd20800
`define FALL_MAX_CODE     16'h7bff
`define SLOPE_MAX_MV      16'd250
`define WARN_MIN          32'd1920
`define WARN_MAX          32'd8384000
`define HOLD_MIN          32'd2176
`define HOLD_MAX          32'd1048320
`define HOLD_STEP_MASK    32'hffffff00
`define RETRY_MIN         32'd1920
`define RETRY_MAX         32'd1342080
`define RETRY_STEP_MASK   32'hfffffff0
`endif

// ### rtl/linear_decode.v
// linear 5-bit exponent, 11-bit mantissa word to 1/16 ms units
`timescale 1ns/1ps
`include "rail_seq_defs.vh"
module linear_decode
(
  // encoded word in, time in subticks out
  input  wire [15:0] word,
  output reg  [31:0] units
);
  wire signed [10:0] mant = word[10:0];
  wire signed [5:0]  expo = {word[15], word[15:11]};
  wire signed [6:0]  sh   = expo + 7'sd4;
  reg         [63:0] wide;

  // signed exponent shift with saturation, negatives read as zero
  always @*
  begin
    wide  = 64'h0;
    units = 32'h0;
    if (!mant[10])
    begin
      if (!sh[6])
        wide = {53'h0, mant} << sh[5:0];
      else
        wide = {53'h0, mant} >> (7'd0 - sh);
      units = (|wide[63:32]) ? 32'hffffffff : wide[31:0];
    end
  end
endmodule // linear_decode

// ### rtl/rail_turnoff_sequencer.v
// turn-off ramp, restart hold and fault retry sequencer for one rail
`timescale 1ns/1ps
`include "rail_seq_defs.vh"
module rail_turnoff_sequencer
#(
  parameter SUBTICK_CYCLES = `SUBTICK_CYC
)
(
  // clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // command port
  input  wire        cmdWrite,
  input  wire        cmdRead,
  input  wire [7:0]  cmdCode,
  input  wire [15:0] cmdData,
  output reg  [15:0] rdData,
  output reg         rdValid,
  // run pin, open drain
  input  wire        runIn,
  output reg         runOut,
  output reg         runOe,
  // operation and analog view
  input  wire        opOn,
  input  wire [15:0] setpoint,
  input  wire [15:0] outputVoltage,
  // fault detections, one-cycle pulses
  input  wire        faultInOv,
  input  wire        faultOutOv,
  input  wire        faultOutUv,
  input  wire        faultStartup,
  // rail control and flags
  output reg  [15:0] vref,
  output reg         stageDrive,
  output reg         startPulse,
  output reg         toffWarn,
  output reg         alert
);
  localparam [2:0] S_OFF   = 3'd0;
  localparam [2:0] S_ON    = 3'd1;
  localparam [2:0] S_DELAY = 3'd2;
  localparam [2:0] S_DIV   = 3'd3;
  localparam [2:0] S_FALL  = 3'd4;
  localparam [2:0] S_DECAY = 3'd5;

  reg  [7:0]  respOutOv, respOutUv, respInOv, respStart, chanConfig;
  reg  [15:0] toffDelayWord, fallWord, warnWord, retryWord, holdWord;
  reg  [7:0]  statusByte, statusWordHi, statusInput;
  reg  [2:0]  state;
  reg  [31:0] subCnt, mainCnt, holdCnt, retryCnt, warnCnt;
  reg         tick, runPrev, faultLatched, retryPending;
  reg  [16:0] divRem;
  reg  [15:0] divQuo, step;
  reg  [4:0]  divCnt;
  wire [79:0] words;
  wire [159:0] units;
  reg  [31:0] fallU, warnU, holdU, retryU;
  reg  [7:0]  resp;
  reg         shutReq, retryReq;
  wire [16:0] divTry;
  wire        decayed, needDecay, canStart, runFall, offCmd;

  // all timing words decode through one decoder each
  assign words = {toffDelayWord, retryWord, holdWord, warnWord, fallWord};
  genvar i;
  generate
    for (i = 0; i < 5; i = i + 1)
    begin : g_dec
      linear_decode u_dec
      (
        .word  (words[16*i +: 16]),
        .units (units[32*i +: 32])
      );
    end
  endgenerate

  // clamp decoded fall, warning, hold and retry times, quantise hold and retry
  always @*
  begin
    fallU = units[31:0];
    if (fallWord == `FALL_MAX_CODE || fallU > `FALL_MAX)
      fallU = `FALL_MAX;
    else if (fallU < `FALL_MIN)
      fallU = `FALL_MIN;
    warnU = units[63:32];
    if (warnU != 32'h0 && warnU < `WARN_MIN)
      warnU = `WARN_MIN;
    else if (warnU > `WARN_MAX)
      warnU = `WARN_MAX;
    holdU = units[95:64];
    if (holdU < `HOLD_MIN)
      holdU = `HOLD_MIN;
    else if (holdU > `HOLD_MAX)
      holdU = `HOLD_MAX;
    holdU = (holdU + 32'hff) & `HOLD_STEP_MASK;
    retryU = units[127:96];
    if (retryU < `RETRY_MIN)
      retryU = `RETRY_MIN;
    else if (retryU > `RETRY_MAX)
      retryU = `RETRY_MAX;
    retryU = (retryU + 32'hf) & `RETRY_STEP_MASK;
  end

  // pick the response byte of the fault that fired
  always @*
  begin
    resp = 8'h00;
    if (faultInOv)
      resp = respInOv;
    else if (faultOutOv)
      resp = respOutOv;
    else if (faultOutUv)
      resp = respOutUv;
    else if (faultStartup)
      resp = respStart;
    shutReq  = (resp[7:6] == `RESP_SHUT) || (resp[7:6] == `RESP_DELAYED);
    retryReq = shutReq && (resp[5:3] == `RETRY_FOREVER);
  end

  assign decayed   = outputVoltage < (setpoint >> 3);
  assign needDecay = (retryPending && !chanConfig[`CFG_NO_RETRY_DECAY]) ||
                     chanConfig[`CFG_DECAY_CHECK];
  assign canStart  = runIn && opOn && !runOe && !faultLatched &&
                     (!retryPending || retryCnt == 32'h0) &&
                     (!needDecay || decayed);
  assign runFall   = runPrev && !runIn;
  assign offCmd    = !runIn || !opOn;
  assign divTry    = {divRem[15:0], divQuo[15]};

  // subtick prescaler
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      subCnt <= 32'h0;
      tick   <= 1'b0;
    end
    else if (subCnt == SUBTICK_CYCLES - 1)
    begin
      subCnt <= 32'h0;
      tick   <= 1'b1;
    end
    else
    begin
      subCnt <= subCnt + 32'h1;
      tick   <= 1'b0;
    end
  end

  // command writes, reads and status flags
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      respOutOv     <= `RST_OUT_OV_RESP;
      respOutUv     <= `RST_OUT_UV_RESP;
      respInOv      <= `RST_IN_OV_RESP;
      respStart     <= `RST_START_RESP;
      toffDelayWord <= `RST_TOFF_DELAY;
      fallWord      <= `RST_FALL_TIME;
      warnWord      <= `RST_WARN_LIMIT;
      retryWord     <= `RST_RETRY_IVL;
      holdWord      <= `RST_RESTART_HOLD;
      chanConfig    <= `RST_CHAN_CONFIG;
      statusByte    <= 8'h00;
      statusWordHi  <= 8'h00;
      statusInput   <= 8'h00;
      rdData        <= 16'h0;
      rdValid       <= 1'b0;
      alert         <= 1'b0;
    end
    else
    begin
      if (cmdWrite)
      begin
        case (cmdCode)
          `CMD_OUT_OV_RESP:  respOutOv <= cmdData[7:0];
          `CMD_OUT_UV_RESP:  respOutUv <= cmdData[7:0];
          `CMD_IN_OV_RESP:   respInOv <= cmdData[7:0];
          `CMD_START_RESP:   respStart <= cmdData[7:0];
          `CMD_TOFF_DELAY:   toffDelayWord <= cmdData;
          `CMD_FALL_TIME:    fallWord <= cmdData;
          `CMD_WARN_LIMIT:   warnWord <= cmdData;
          `CMD_RETRY_IVL:    retryWord <= cmdData;
          `CMD_RESTART_HOLD: holdWord <= cmdData;
          `CMD_CHAN_CONFIG:  chanConfig <= cmdData[7:0];
          `CMD_CLEAR_FAULTS:
          begin
            statusByte   <= 8'h00;
            statusWordHi <= 8'h00;
            statusInput  <= 8'h00;
          end
          default: ;
        endcase
      end
      // set after clear so a same-cycle event survives
      if (faultInOv)
      begin
        statusByte[`SB_NONE_ABOVE] <= 1'b1;
        statusWordHi[`SWH_INPUT]   <= 1'b1;
        statusInput[`SIN_IN_OV]    <= 1'b1;
      end
      alert   <= |statusInput || faultInOv;
      rdValid <= cmdRead;
      if (cmdRead)
      begin
        case (cmdCode)
          `CMD_OUT_OV_RESP:  rdData <= {8'h00, respOutOv};
          `CMD_OUT_UV_RESP:  rdData <= {8'h00, respOutUv};
          `CMD_IN_OV_RESP:   rdData <= {8'h00, respInOv};
          `CMD_START_RESP:   rdData <= {8'h00, respStart};
          `CMD_TOFF_DELAY:   rdData <= toffDelayWord;
          `CMD_FALL_TIME:    rdData <= fallWord;
          `CMD_WARN_LIMIT:   rdData <= warnWord;
          `CMD_RETRY_IVL:    rdData <= retryWord;
          `CMD_RESTART_HOLD: rdData <= holdWord;
          `CMD_CHAN_CONFIG:  rdData <= {8'h00, chanConfig};
          `CMD_STATUS_BYTE:  rdData <= {8'h00, statusByte};
          `CMD_STATUS_WORD:  rdData <= {statusWordHi, statusByte};
          `CMD_STATUS_INPUT: rdData <= {8'h00, statusInput};
          default:           rdData <= 16'h0;
        endcase
      end
    end
  end

  // run pin hold after a falling edge
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      runPrev <= 1'b0;
      runOut  <= 1'b0;
      runOe   <= 1'b0;
      holdCnt <= 32'h0;
    end
    else
    begin
      runPrev <= runIn;
      runOut  <= 1'b0;
      if (runFall && !runOe)
      begin
        runOe   <= 1'b1;
        holdCnt <= holdU;
      end
      else if (runOe && tick)
      begin
        if (holdCnt <= 32'h1)
        begin
          holdCnt <= 32'h0;
          runOe   <= 1'b0;
        end
        else
          holdCnt <= holdCnt - 32'h1;
      end
    end
  end

  // retry interval timer, started when the fault is seen
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      retryCnt     <= 32'h0;
      retryPending <= 1'b0;
      faultLatched <= 1'b0;
    end
    else if (shutReq && state != S_OFF && state != S_DECAY)
    begin
      retryPending <= retryReq;
      faultLatched <= !retryReq;
      retryCnt     <= retryU;
    end
    else if (offCmd)
    begin
      // off then on clears latched and retrying faults
      retryPending <= 1'b0;
      faultLatched <= 1'b0;
      retryCnt     <= 32'h0;
    end
    else
    begin
      if (startPulse)
        retryPending <= 1'b0;
      if (tick && retryCnt != 32'h0)
        retryCnt <= retryCnt - 32'h1;
    end
  end

  // main sequence: on, delay, slope divide, ramp, decay watch
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      state      <= S_OFF;
      mainCnt    <= 32'h0;
      warnCnt    <= 32'h0;
      vref       <= 16'h0;
      stageDrive <= 1'b0;
      startPulse <= 1'b0;
      toffWarn   <= 1'b0;
      divRem     <= 17'h0;
      divQuo     <= 16'h0;
      divCnt     <= 5'h0;
      step       <= 16'h0;
    end
    else
    begin
      startPulse <= 1'b0;
      case (state)
        S_OFF:
        begin
          if (canStart)
          begin
            startPulse <= 1'b1;
            stageDrive <= 1'b1;
            toffWarn   <= 1'b0;
            vref       <= setpoint;
            state      <= S_ON;
          end
        end
        S_ON:
        begin
          vref <= setpoint;
          if (shutReq)
            state <= S_DIV;
          else if (offCmd)
          begin
            mainCnt <= units[159:128];
            state   <= S_DELAY;
          end
          divRem <= 17'h0;
          divCnt <= 5'd16;
        end
        S_DELAY:
        begin
          if (shutReq || mainCnt == 32'h0)
            state <= S_DIV;
          else if (tick)
            mainCnt <= mainCnt - 32'h1;
          divQuo <= vref;
        end
        S_DIV:
        begin
          // one quotient bit per cycle: step = setpoint / fall time
          if (divCnt == 5'd16 && divRem == 17'h0 && divQuo != vref)
            divQuo <= vref;
          else if (divCnt != 5'h0)
          begin
            if (divTry >= fallU[16:0])
            begin
              divRem <= divTry - fallU[16:0];
              divQuo <= {divQuo[14:0], 1'b1};
            end
            else
            begin
              divRem <= divTry;
              divQuo <= {divQuo[14:0], 1'b0};
            end
            divCnt <= divCnt - 5'h1;
          end
          else
          begin
            if (divQuo > `SLOPE_MAX_MV)
              step <= `SLOPE_MAX_MV;
            else if (divQuo == 16'h0)
              step <= 16'h1;
            else
              step <= divQuo;
            state <= S_FALL;
          end
        end
        S_FALL:
        begin
          if (vref == 16'h0)
          begin
            stageDrive <= 1'b0;
            warnCnt    <= 32'h0;
            state      <= S_DECAY;
          end
          else if (tick)
            vref <= (vref > step) ? vref - step : 16'h0;
        end
        S_DECAY:
        begin
          if (!chanConfig[`CFG_DECAY_CHECK] || decayed)
            state <= S_OFF;
          else if (tick)
          begin
            warnCnt <= warnCnt + 32'h1;
            if (warnU != 32'h0 && warnCnt + 32'h1 >= warnU)
              toffWarn <= 1'b1;
          end
        end
        default: state <= S_OFF;
      endcase
    end
  end
endmodule // rail_turnoff_sequencer

// ### tb/rail_seq_sva.sv
// assertion checker for the rail turn-off sequencer
`timescale 1ns/1ps
module rail_seq_sva
#(
  parameter SUBTICK_CYCLES = 3125
)
(
  // clock and reset
  input wire        clk,
  input wire        reset_n,
  // command port
  input wire        cmdWrite,
  input wire        cmdRead,
  input wire [7:0]  cmdCode,
  input wire [15:0] cmdData,
  input wire [15:0] rdData,
  input wire        rdValid,
  // run pin
  input wire        runIn,
  input wire        runOut,
  input wire        runOe,
  // operation and analog view
  input wire        opOn,
  input wire [15:0] setpoint,
  input wire [15:0] outputVoltage,
  // fault pulses
  input wire        faultInOv,
  input wire        faultOutOv,
  input wire        faultOutUv,
  input wire        faultStartup,
  // rail control and flags
  input wire [15:0] vref,
  input wire        stageDrive,
  input wire        startPulse,
  input wire        toffWarn,
  input wire        alert
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ramp slope and three-state point
  a_slope_limit: assert property (stageDrive && $past(stageDrive)
    && vref < $past(vref) |-> $past(vref) - vref <= 16'd250)
    else $error("ramp step above limit");
  a_tristate_zero: assert property ($fell(stageDrive) |-> vref == 0)
    else $error("stage released before reference reached zero");
  // command port answers
  a_read_answer: assert property (cmdRead |=> rdValid)
    else $error("read not answered");
  a_read_quiet: assert property (!cmdRead |=> !rdValid)
    else $error("read valid without read");
  // run pin pull and hold
  a_run_pull: assert property ($past(runIn) && !runIn && !runOe |=> runOe)
    else $error("run fall not answered by pull");
  a_run_hold: assert property ($rose(runOe) |-> runOe [*8])
    else $error("run pull too short");
  a_no_start_pulled: assert property (runOe |-> !startPulse)
    else $error("start while run pulled low");
  // warning and alert
  a_warn_after_ramp: assert property ($rose(toffWarn)
    |-> !stageDrive && vref == 0)
    else $error("warning before ramp done");
  a_alert_input: assert property (faultInOv |-> ##2 alert)
    else $error("alert missing after input fault");
  // main scenarios reached
  c_ramp_done: cover property ($fell(stageDrive));
  c_warn: cover property ($rose(toffWarn));
  c_hold_end: cover property ($fell(runOe));
  c_start: cover property (startPulse);
endmodule // rail_seq_sva

bind rail_turnoff_sequencer rail_seq_sva
  #(.SUBTICK_CYCLES(SUBTICK_CYCLES)) chk_u
(
  .clk(clk), .reset_n(reset_n), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
  .cmdCode(cmdCode), .cmdData(cmdData), .rdData(rdData),
  .rdValid(rdValid), .runIn(runIn), .runOut(runOut), .runOe(runOe),
  .opOn(opOn), .setpoint(setpoint), .outputVoltage(outputVoltage),
  .faultInOv(faultInOv), .faultOutOv(faultOutOv),
  .faultOutUv(faultOutUv), .faultStartup(faultStartup), .vref(vref),
  .stageDrive(stageDrive), .startPulse(startPulse),
  .toffWarn(toffWarn), .alert(alert)
);

// ### tb/rail_plant_model.sv
// rail output and run line model for the sequencer bench
`timescale 1ns/1ps
module rail_plant_model
(
  // clock and controls
  input  wire        clk,
  input  wire        hold,
  input  wire        hostRun,
  // sequencer side
  input  wire [15:0] vref,
  input  wire        stageDrive,
  input  wire        runOut,
  input  wire        runOe,
  // model outputs
  output reg  [15:0] outputVoltage,
  output wire        runIn
);
  initial outputVoltage = 16'h0000;
  // open-drain run line, follows hostRun when nobody pulls
  assign runIn = runOe ? runOut : hostRun;
  // output follows reference, sticks when loaded, else decays
  always @(posedge clk)
    if (hold)
      outputVoltage <= outputVoltage;
    else if (stageDrive)
      outputVoltage <= vref;
    else
      outputVoltage <= outputVoltage >> 1;
endmodule // rail_plant_model

// ### tb/testbench.sv
// self-checking bench for the rail turn-off sequencer
`timescale 1ns/1ps
module testbench;
  localparam [239:0] rstTab = {8'h41, 16'h00b8, 8'h45, 16'h00b8,
    8'h56, 16'h0080, 8'h63, 16'h00b8, 8'h64, 16'h8000, 8'h65, 16'hd200,
    8'h66, 16'hf258, 8'hdb, 16'hfabc, 8'hdc, 16'hfbe8, 8'hd0, 16'h0000};
  reg         clk = 1'b0;
  reg         reset_n = 1'b0;
  reg         cmdWrite = 1'b0;
  reg         cmdRead = 1'b0;
  reg  [7:0]  cmdCode = 8'h00;
  reg  [15:0] cmdData = 16'h0000;
  reg         opOn = 1'b0;
  reg         hostRun = 1'b1;
  reg         hold = 1'b0;
  reg  [3:0]  fault = 4'h0;
  wire [15:0] rdData;
  wire [15:0] vref;
  wire [15:0] outputVoltage;
  wire        rdValid;
  wire        runIn;
  wire        runOut;
  wire        runOe;
  wire        stageDrive;
  wire        startPulse;
  wire        toffWarn;
  wire        alert;
  integer     n_fail = 0;
  integer     check_count = 0;
  integer     cyc = 0;
  integer     n;
  integer     i;
  integer     t0;

  rail_turnoff_sequencer #(.SUBTICK_CYCLES(4)) dut_u
  (
    .clk(clk), .reset_n(reset_n), .cmdWrite(cmdWrite),
    .cmdRead(cmdRead), .cmdCode(cmdCode), .cmdData(cmdData),
    .rdData(rdData), .rdValid(rdValid), .runIn(runIn),
    .runOut(runOut), .runOe(runOe), .opOn(opOn),
    .setpoint(16'h07d0), .outputVoltage(outputVoltage),
    .faultInOv(fault[3]), .faultOutOv(fault[2]),
    .faultOutUv(fault[1]), .faultStartup(fault[0]), .vref(vref),
    .stageDrive(stageDrive), .startPulse(startPulse),
    .toffWarn(toffWarn), .alert(alert)
  );
  rail_plant_model plant_u
  (
    .clk(clk), .hold(hold), .hostRun(hostRun), .vref(vref),
    .stageDrive(stageDrive), .runOut(runOut), .runOe(runOe),
    .outputVoltage(outputVoltage), .runIn(runIn)
  );

  // clock and run ceiling
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      n_fail = n_fail + 1;
      $display("wrong value at %0t: run timed out", $time);
      end_sim;
    end
  end

  task end_sim;
    begin
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  task chk(input [15:0] got, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
        n_fail = n_fail + 1;
        $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask

  task wr(input [7:0] c, input [15:0] d);
    begin
      @(posedge clk);
      cmdWrite <= 1'b1;
      cmdCode <= c;
      cmdData <= d;
      @(posedge clk);
      cmdWrite <= 1'b0;
    end
  endtask

  task rd(input [7:0] c, input [15:0] e);
    begin
      @(posedge clk);
      cmdRead <= 1'b1;
      cmdCode <= c;
      @(posedge clk);
      cmdRead <= 1'b0;
      #1 chk(rdData, e);
      chk(16'(rdValid), 16'h0001);
    end
  endtask

  function sig(input integer k);
    case (k)
      0: sig = startPulse;
      1: sig = !stageDrive;
      2: sig = toffWarn;
      3: sig = runOe;
      default: sig = !runOe;
    endcase
  endfunction

  // n counts edges until the chosen flag is seen
  task waitOn(input integer k, input integer lim);
    begin
      n = 0;
      do
      begin
        @(posedge clk);
        #1 n = n + 1;
      end
      while (!sig(k) && n < lim);
    end
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    // defaults, refused code, byte and word settings
    for (i = 0; i < 10; i = i + 1)
      rd(rstTab[i*24+16 +: 8], rstTab[i*24 +: 16]);
    wr(8'hee, 16'h1234);
    rd(8'hee, 16'h0000);
    wr(8'h41, 16'h3480);
    rd(8'h41, 16'h0080);
    wr(8'h41, 16'h00b8);
    wr(8'h65, 16'h0000);
    wr(8'hdb, 16'hf8f0);
    wr(8'hdc, 16'h0848);
    rd(8'hdc, 16'h0848);
    // turn-off ramp and warning timer in three set-ups
    for (i = 0; i < 3; i = i + 1)
    begin
      @(posedge clk) hold <= 1'b0;
      wr(8'hd0, i == 2 ? 16'h0000 : 16'h0002);
      wr(8'h66, i == 1 ? 16'h0000 : 16'h0078);
      @(posedge clk) opOn <= 1'b1;
      waitOn(0, 800);
      chk(16'(startPulse), 16'h0001);
      repeat (600) @(posedge clk);
      hold <= 1'b1;
      opOn <= 1'b0;
      waitOn(1, 400);
      chk(16'(n >= 12), 16'h0001);
      chk(vref, 16'h0000);
      waitOn(2, 7760);
      if (i == 0)
        chk(16'(toffWarn && n >= 7670), 16'h0001);
      else
        chk(16'(toffWarn), 16'h0000);
    end
    // run pin fall, hold time, then start
    @(posedge clk) hold <= 1'b0;
    opOn <= 1'b1;
    waitOn(0, 800);
    chk(16'(startPulse), 16'h0001);
    @(posedge clk) hostRun <= 1'b0;
    waitOn(3, 4);
    chk(16'(n), 16'h0001);
    @(posedge clk) hostRun <= 1'b1;
    waitOn(4, 9400);
    chk(16'(n >= 9200 && n <= 9225), 16'h0001);
    waitOn(0, 200);
    chk(16'(startPulse), 16'h0001);
    // retrying faults skip the delay and wait the interval
    wr(8'hd0, 16'h0001);
    wr(8'h64, 16'h0064);
    for (i = 0; i < 3; i = i + 1)
    begin
      repeat (600) @(posedge clk);
      fault <= 4'h4 >> i;
      #1 t0 = cyc;
      @(posedge clk) fault <= 4'h0;
      waitOn(1, 400);
      chk(16'(!stageDrive), 16'h0001);
      waitOn(0, 7800);
      t0 = cyc - t0;
      chk(16'(startPulse && t0 >= 7670 && t0 <= 7700), 16'h0001);
    end
    // input overvoltage status and alert
    wr(8'h03, 16'h0000);
    repeat (600) @(posedge clk);
    fault <= 4'h8;
    @(posedge clk) fault <= 4'h0;
    waitOn(1, 400);
    chk(16'(!stageDrive), 16'h0001);
    rd(8'h78, 16'h0001);
    rd(8'h79, 16'h2001);
    rd(8'h7c, 16'h0080);
    chk(16'(alert), 16'h0001);
    wr(8'h03, 16'h0000);
    repeat (2) @(posedge clk);
    #1 chk(16'(alert), 16'h0000);
    rd(8'h7c, 16'h0000);
    end_sim;
  end
endmodule // testbench
